// File: clk_select.sv
`timescale 1ns/1ns
// Clock source selector with optional synchroniser and edge detector.
module clk_select
	import tmr_pkg::*;
(
	input  wire logic        aclk,      // System clock.
	input  wire logic        aresetn,   // Synchronous reset, active low.
	input  wire logic [3:0]  sel,       // Clock select code.
	input  wire logic        sync_off,  // One bypasses the synchroniser.
	input  wire logic [15:0] src_in,    // Source levels indexed by code.
	tick_if.src              tk         // One-cycle tick per rising source edge; a tick every cycle for the system clock.
);
	typedef struct packed
	{
		logic [15:0] s1;
		logic [15:0] s2;
		logic        prev;
		logic        tick;
	} sel_state_t;
	sel_state_t q, d;
	logic lvl;
	always_comb
	begin
		d = q;
		d.s1 = src_in;
		d.s2 = q.s1;
		// The system clock and its quarter are already on aclk, so they skip the flops. [R2]
		if (sel == cs_sys)
			lvl = 1'b1;
		else if (sel == cs_sysq || sync_off)
			lvl = src_in[sel];
		else
			lvl = q.s2[sel];
		d.prev = lvl;
		if (sel == cs_sys)
			d.tick = 1'b1;
		else if (sel >= cs_res_lo)
			d.tick = 1'b0; // Reserved codes give no clock. [R5]
		else
			d.tick = lvl & ~q.prev; // [R6]
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			q <= '0;
		else
			q <= d;
	end
	assign tk.tick = q.tick;
endmodule

// File: tick_if.sv
`timescale 1ns/1ns
// Interface carrying the selected clock events from the source selector to the counter.
interface tick_if;
	logic tick;
	modport src (output tick);
	modport dst (input tick);
endinterface

// File: timer1_clock_and_capture_high_tb_top.sv
`timescale 1ns/1ns
// Self-checking testbench for the timer core over its register bus.
module timer1_clock_and_capture_high_tb_top
	import tmr_pkg::*;
;
	logic        aclk = 1'b0, aresetn = 1'b0;
	// Both response readies stay high, so calls in a row never drive them twice in one step.
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b1;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hf, cell_out = 4'h0;
	logic        ext_clk_pin = 1'b0, hf_osc = 1'b0, lf_osc = 1'b0, medium_internal_osc = 1'b0;
	logic        medium_osc_slow = 1'b0, sec_osc = 1'b0, sysq_clk = 1'b0, t0_overflow = 1'b0;
	logic        capture_evt = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic [31:0] s_axi_rdata, rv, v, noise;
	logic        compare_match, gate_q;
	logic [9:0]  pwm_duty;
	logic [15:0] cv;
	logic [31:0] rng = 32'd39724;
	logic [2:0]  ph = 3'h0;
	int          fail_count = 0, checks_done = 0;

	timer_core i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_clk_pin, .hf_osc,
		.lf_osc, .medium_internal_osc, .medium_osc_slow, .sec_osc, .sysq_clk, .t0_overflow,
		.cell_out, .capture_evt, .compare_match, .pwm_duty, .gate_q);

	always #5 aclk = ~aclk;

	function automatic logic [31:0] xs();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction

	// Every source but medium_internal_osc carries noise so that a wrong source choice shows up in the counts.
	always @(posedge aclk)
	begin
		noise = xs();
		ph <= ph + 3'h1;
		medium_internal_osc <= ph[2];
		{ext_clk_pin, hf_osc, lf_osc, medium_osc_slow, sec_osc, sysq_clk, t0_overflow,
			cell_out} <= noise[10:0];
	end

	task automatic summarize();
		$display("checks %0d errors %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Readies are sampled at the falling edge, where they are settled for the next rising one.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw, w, da, dw;
		da = 1'b0;
		dw = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do
		begin
			@(negedge aclk);
			aw = s_axi_awvalid & s_axi_awready;
			w = s_axi_wvalid & s_axi_wready;
			@(posedge aclk);
			if (aw)
				s_axi_awvalid <= 1'b0;
			if (w)
				s_axi_wvalid <= 1'b0;
			da = da | aw;
			dw = dw | w;
		end while (!(da && dw));
		do
		begin
			@(negedge aclk);
			aw = s_axi_bvalid;
			rsp = s_axi_bresp;
			@(posedge aclk);
		end while (!aw);
	endtask

	task automatic rd(input logic [7:0] a);
		logic t;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do
		begin
			@(negedge aclk);
			t = s_axi_arvalid & s_axi_arready;
			@(posedge aclk);
		end while (!t);
		s_axi_arvalid <= 1'b0;
		do
		begin
			@(negedge aclk);
			t = s_axi_rvalid;
			rv = s_axi_rdata;
			rsp = s_axi_rresp;
			@(posedge aclk);
		end while (!t);
	endtask

	task automatic cnt();
		rd(count_lo_offset);
		cv[7:0] = rv[7:0];
		rd(count_hi_offset);
		cv[15:8] = rv[7:0];
	endtask

	// Counts over a window of n cycles, then checks that a stopped counter holds still.
	task automatic run(input logic [7:0] ctl, input logic [3:0] cs, input int n);
		logic [15:0] c0;
		wr(ctrl_offset, 32'h0);
		wr(count_lo_offset, 32'h0);
		wr(count_hi_offset, 32'h0);
		wr(clksrc_offset, {28'h0, cs});
		wr(ctrl_offset, {24'h0, ctl | 8'h01});
		repeat (n) @(posedge aclk);
		@(negedge aclk);
		chk("gate_on", 32'h1, gate_q);
		@(posedge aclk);
		wr(ctrl_offset, {24'h0, ctl});
		@(negedge aclk);
		chk("gate_off", 32'h0, gate_q);
		@(posedge aclk);
		cnt();
		c0 = cv;
		repeat (40) @(posedge aclk);
		cnt();
		chk("stopped", c0, cv);
	endtask

	initial
	begin
		repeat (20000) @(posedge aclk);
		fail_count++;
		summarize();
	end

	initial
	begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(ctrl_offset);
		chk("ctrl_reset", {24'h0, ctrl_reset}, rv);
		rd(clksrc_offset);
		chk("clksrc_reset", {24'h0, clksrc_reset}, rv);
		repeat (4)
		begin
			v = xs();
			wr(ctrl_offset, v);
			chk("okay_wr", {30'h0, resp_okay}, {30'h0, rsp});
			rd(ctrl_offset);
			chk("okay_rd", {30'h0, resp_okay}, {30'h0, rsp});
			chk("ctrl_rw", v & {24'h0, ctrl_mask}, rv);
			wr(clksrc_offset, v >> 8);
			rd(clksrc_offset);
			chk("clksrc_rw", (v >> 8) & {24'h0, clksrc_mask}, rv);
		end
		rd(8'h1c);
		chk("unmapped_resp", {30'h0, resp_slverr}, {30'h0, rsp});
		chk("unmapped_data", 32'h0, rv);
		wr(8'h1c, 32'hff);
		chk("unmapped_wr", {30'h0, resp_slverr}, {30'h0, rsp});
		run(8'h30, cs_sys, 80);
		chk("div8", 32'h1, cv >= 9 && cv <= 12);
		run(8'h00, cs_sys, 80);
		chk("div1", 32'h1, cv >= 80 && cv <= 90);
		run(8'h04, cs_sys, 80);
		chk("sync_ignored", 32'h1, cv >= 80 && cv <= 90);
		run(8'h00, cs_res_lo, 80);
		chk("reserved", 32'h0, cv);
		run(8'h00, 4'h5, 80);
		chk("med_osc", 32'h1, cv >= 9 && cv <= 12);
		run(8'h24, 4'h5, 80);
		chk("med_osc_div4", 32'h1, cv >= 2 && cv <= 3);
		wr(ctrl_offset, 32'h2);
		wr(count_hi_offset, 32'h12);
		wr(count_lo_offset, 32'h34);
		cnt();
		chk("wide_commit", 32'h1234, cv);
		wr(count_hi_offset, 32'h77);
		cnt();
		chk("wide_pending", 32'h1234, cv);
		wr(count_lo_offset, 32'h0);
		cnt();
		// The low read refilled the one shared high buffer, so the pending 77 is gone.
		chk("wide_late", 32'h1200, cv);
		wr(ctrl_offset, 32'h0);
		wr(count_hi_offset, 32'h5a);
		cnt();
		chk("byte_hi", 32'h5a00, cv);
		wr(mode_offset, 32'h1);
		capture_evt <= 1'b1;
		repeat (6) @(posedge aclk);
		capture_evt <= 1'b0;
		rd(cchigh_offset);
		chk("capture", 32'h5a, rv);
		wr(mode_offset, 32'h2);
		for (int i = 0; i < 2; i++)
		begin
			wr(cchigh_offset, 32'h5a + i);
			repeat (3) @(posedge aclk);
			@(negedge aclk);
			chk("match", 32'(1 - i), compare_match);
			@(posedge aclk);
			rd(status_offset);
			chk("status_match", 32'(4 - 4 * i), rv & 32'h6);
		end
		for (int i = 0; i < 4; i++)
		begin
			v = (i == 0) ? 32'hfc : (i == 1) ? 32'h03 : xs();
			wr(cchigh_offset, {24'h0, v[7:0]});
			wr(mode_offset, 32'h3);
			repeat (3) @(posedge aclk);
			@(negedge aclk);
			chk("pwm_right", {22'h0, v[1:0], 8'h00}, pwm_duty);
			@(posedge aclk);
			wr(mode_offset, 32'h7);
			repeat (3) @(posedge aclk);
			@(negedge aclk);
			chk("pwm_left", {22'h0, v[7:0], 2'b00}, pwm_duty);
			@(posedge aclk);
		end
		summarize();
	end
endmodule

// File: timer_core.sv
`timescale 1ns/1ns
// Timer with prescaler, selectable clock, 16-bit access and capture/compare high byte.
// What this block does
// R1: Prescaler 2-bit field divides by 1,2,4,8.
// R2: Sync bit ignored for system clocks.
// R3: Count only when enabled; clear gate flop.
// R4: Wide mode buffers 16-bit counter access.
// R5: 4-bit clock select; reserved codes idle.
// R6: Code 0101 routes medium internal oscillator.
// R7: Capture loads high byte from counter.
// R8: Compare matches high byte with counter.
// R9: Right-aligned PWM uses bits 1:0 only.
// R10: Left-aligned PWM uses all eight bits.
module timer_core
	import tmr_pkg::*;
(
	input  wire logic        aclk,          // System clock, 100 MHz.
	input  wire logic        aresetn,       // Synchronous reset, active low.
	input  wire logic [7:0]  s_axi_awaddr,  // Write address.
	input  wire logic        s_axi_awvalid, // Write address valid.
	output logic             s_axi_awready, // Write address ready.
	input  wire logic [31:0] s_axi_wdata,   // Write data.
	input  wire logic [3:0]  s_axi_wstrb,   // Write strobes.
	input  wire logic        s_axi_wvalid,  // Write data valid.
	output logic             s_axi_wready,  // Write data ready.
	output logic [1:0]       s_axi_bresp,   // Write response.
	output logic             s_axi_bvalid,  // Write response valid.
	input  wire logic        s_axi_bready,  // Write response ready.
	input  wire logic [7:0]  s_axi_araddr,  // Read address.
	input  wire logic        s_axi_arvalid, // Read address valid.
	output logic             s_axi_arready, // Read address ready.
	output logic [31:0]      s_axi_rdata,   // Read data.
	output logic [1:0]       s_axi_rresp,   // Read response.
	output logic             s_axi_rvalid,  // Read data valid.
	input  wire logic        s_axi_rready,  // Read data ready.
	input  wire logic        ext_clk_pin,   // External clock pin.
	input  wire logic        hf_osc,        // High-frequency oscillator level.
	input  wire logic        lf_osc,        // Low-frequency oscillator level.
	input  wire logic        medium_internal_osc,  // 500 kHz oscillator level.
	input  wire logic        medium_osc_slow,      // 32 kHz oscillator level.
	input  wire logic        sec_osc,       // Secondary oscillator level.
	input  wire logic        sysq_clk,      // System clock quarter enable level.
	input  wire logic        t0_overflow,   // Other timer overflow level.
	input  wire logic [3:0]  cell_out,      // Logic cell outputs.
	input  wire logic        capture_evt,   // Capture event level.
	output logic             compare_match, // High byte matches counter high byte.
	output logic [9:0]       pwm_duty,      // Duty value from the high byte.
	output logic             gate_q         // Gate flip-flop state.
);
	typedef struct packed
	{
		logic [7:0]  ctrl;
		logic [7:0]  clksrc;
		logic [7:0]  cchigh;
		logic [7:0]  mode;
		logic [15:0] count;
		logic [7:0]  hi_buf;
		logic [2:0]  pre;
		logic        gate;
		logic [1:0]  cap_s;
		logic        cap_prev;
		logic        match;
		logic [9:0]  duty;
		logic        aw_got;
		logic        w_got;
		logic [7:0]  aw_addr;
		logic [31:0] w_data;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        aw_rdy;
		logic        w_rdy;
		logic        ar_rdy;
	} core_state_t;
	core_state_t q, d;
	tick_if tk ();
	logic [15:0] srcs;
	logic        do_wr;
	logic        do_rd;
	logic [2:0]  pre_max;
	logic        inc;
	unit_function_mode_t fmode;
	assign srcs = {2'b00, cell_out, t0_overflow, 1'b0, sec_osc, medium_osc_slow,
		medium_internal_osc, lf_osc, hf_osc, 1'b1, sysq_clk, ext_clk_pin}; // [R5] [R6]
	clk_select u_sel
	(
		.aclk     (aclk),
		.aresetn  (aresetn),
		.sel      (q.clksrc[3:0]),
		.sync_off (q.ctrl[ctrl_sync_bit]),
		.src_in   (srcs),
		.tk       (tk.src)
	);
	assign fmode = unit_function_mode_t'(q.mode[1:0]);
	assign do_wr = q.aw_got && q.w_got && !q.bvalid;
	assign do_rd = s_axi_arvalid && !q.rvalid;
	always_comb
	begin
		d = q;
		inc = 1'b0;
		if (s_axi_awvalid && !q.aw_got)
		begin
			d.aw_got = 1'b1;
			d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !q.w_got)
		begin
			d.w_got = 1'b1;
			d.w_data = s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
				{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
		end
		if (q.bvalid && s_axi_bready)
			d.bvalid = 1'b0;
		if (q.rvalid && s_axi_rready)
			d.rvalid = 1'b0;
		// Prescaler: divide the tick by 2 to the power of the field. [R1]
		case (q.ctrl[ctrl_ps_lsb +: 2])
			2'b00:   pre_max = 3'd0;
			2'b01:   pre_max = 3'd1;
			2'b10:   pre_max = 3'd3;
			2'b11:   pre_max = 3'd7;
			default: pre_max = 3'd0;
		endcase
		if (!q.ctrl[ctrl_on_bit])
		begin
			d.pre = 3'd0;
			d.gate = 1'b0; // [R3]
		end
		else
		begin
			d.gate = 1'b1;
			if (tk.tick)
			begin
				if (q.pre >= pre_max)
				begin
					d.pre = 3'd0;
					inc = 1'b1;
				end
				else
					d.pre = q.pre + 3'd1; // [R1]
			end
		end
		if (inc)
			d.count = q.count + 16'h0001; // [R3]
		// Capture samples a synchronised rising edge of the event input.
		d.cap_s = {q.cap_s[0], capture_evt};
		d.cap_prev = q.cap_s[1];
		d.match = (fmode == fn_compare) && (q.cchigh == q.count[15:8]); // [R8]
		if (fmode == fn_pwm)
		begin
			if (q.mode[2])
				d.duty = {q.cchigh, 2'b00}; // [R10]
			else
				d.duty = {q.cchigh[1:0], 8'h00}; // [R9]
		end
		else
			d.duty = 10'h000;
		if (do_wr)
		begin
			d.aw_got = 1'b0;
			d.w_got = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = resp_okay;
			case (q.aw_addr)
				ctrl_offset:   d.ctrl = q.w_data[7:0] & ctrl_mask;
				clksrc_offset: d.clksrc = q.w_data[7:0] & clksrc_mask; // [R5]
				cchigh_offset: d.cchigh = q.w_data[7:0];
				mode_offset:   d.mode = {5'h00, q.w_data[2:0]};
				count_lo_offset:
					// Wide mode commits the buffered high byte with the low byte. [R4]
					if (q.ctrl[ctrl_wide_bit])
						d.count = {q.hi_buf, q.w_data[7:0]};
					else
						d.count = {d.count[15:8], q.w_data[7:0]};
				count_hi_offset:
					if (q.ctrl[ctrl_wide_bit])
						d.hi_buf = q.w_data[7:0]; // [R4]
					else
						d.count = {q.w_data[7:0], d.count[7:0]};
				default: d.bresp = resp_slverr;
			endcase
		end
		// Capture follows the bus write so that it wins a clash on the high byte.
		if (fmode == fn_capture && q.cap_s[1] && !q.cap_prev)
			d.cchigh = q.count[15:8]; // [R7]
		if (do_rd)
		begin
			d.rvalid = 1'b1;
			d.rresp = resp_okay;
			d.rdata = 32'h0000_0000;
			case (s_axi_araddr)
				ctrl_offset:   d.rdata[7:0] = q.ctrl;
				clksrc_offset: d.rdata[7:0] = q.clksrc;
				cchigh_offset: d.rdata[7:0] = q.cchigh;
				mode_offset:   d.rdata[7:0] = q.mode;
				count_lo_offset:
				begin
					d.rdata[7:0] = q.count[7:0];
					if (q.ctrl[ctrl_wide_bit])
						d.hi_buf = q.count[15:8]; // [R4]
				end
				count_hi_offset:
					d.rdata[7:0] = q.ctrl[ctrl_wide_bit] ? q.hi_buf : q.count[15:8];
				status_offset: d.rdata[2:0] = {q.match, q.gate, tk.tick};
				default:       d.rresp = resp_slverr;
			endcase
		end
		// Readies are kept in flops of their own so that every bus output leaves a register.
		d.aw_rdy = !d.aw_got;
		d.w_rdy  = !d.w_got;
		d.ar_rdy = !d.rvalid;
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			q <= '0;
			q.ctrl <= ctrl_reset;
			q.clksrc <= clksrc_reset;
			q.cchigh <= cchigh_reset;
			q.aw_rdy <= 1'b1;
			q.w_rdy <= 1'b1;
			q.ar_rdy <= 1'b1;
		end
		else
			q <= d;
	end
	assign s_axi_awready = q.aw_rdy;
	assign s_axi_wready  = q.w_rdy;
	assign s_axi_bvalid  = q.bvalid;
	assign s_axi_bresp   = q.bresp;
	assign s_axi_arready = q.ar_rdy;
	assign s_axi_rvalid  = q.rvalid;
	assign s_axi_rdata   = q.rdata;
	assign s_axi_rresp   = q.rresp;
	assign compare_match = q.match;
	assign pwm_duty      = q.duty;
	assign gate_q        = q.gate;

	a_stop_clears_gate: assert property (@(posedge aclk) disable iff (!aresetn) // [R3]
		!q.ctrl[ctrl_on_bit] |=> !q.gate && $stable(q.count) || $past(do_wr))
		else $error("gate or count moved while disabled");
	a_count_steps: assert property (@(posedge aclk) disable iff (!aresetn) // [R1]
		(q.count != $past(q.count)) |-> $past(inc) || $past(do_wr))
		else $error("counter changed without a tick");
	a_div8_spacing: assert property (@(posedge aclk) disable iff (!aresetn) // [R1]
		inc && q.ctrl[5:4] == 2'b11 |=> (!inc || q.ctrl[5:4] != 2'b11) [*7])
		else $error("divide by eight too fast");
	a_capture_load: assert property (@(posedge aclk) disable iff (!aresetn) // [R7]
		fmode == fn_capture && q.cap_s[1] && !q.cap_prev
		|=> q.cchigh == $past(q.count[15:8]))
		else $error("capture did not load high byte");
	a_compare_flag: assert property (@(posedge aclk) disable iff (!aresetn) // [R8]
		fmode == fn_compare && q.cchigh == q.count[15:8] |=> compare_match)
		else $error("compare match missed");
	a_pwm_right: assert property (@(posedge aclk) disable iff (!aresetn) // [R9]
		fmode == fn_pwm && !q.mode[2]
		|=> pwm_duty[9:8] == $past(q.cchigh[1:0]) && pwm_duty[7:0] == 8'h00)
		else $error("right aligned duty used high bits");
	a_pwm_left: assert property (@(posedge aclk) disable iff (!aresetn) // [R10]
		fmode == fn_pwm && q.mode[2] |=> pwm_duty[9:2] == $past(q.cchigh))
		else $error("left aligned duty wrong");
	a_reserved_idle: assert property (@(posedge aclk) disable iff (!aresetn) // [R5]
		q.clksrc[3:0] >= cs_res_lo [*2] |=> !tk.tick)
		else $error("reserved source ticked");
	a_sys_tick: assert property (@(posedge aclk) disable iff (!aresetn) // [R2]
		q.clksrc[3:0] == cs_sys [*2] |-> tk.tick)
		else $error("system clock not every cycle");
	a_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
		do_wr |=> s_axi_bvalid)
		else $error("no write response");
	c_capture: cover property (@(posedge aclk) fmode == fn_capture && q.cap_s[1] && !q.cap_prev);
	c_match: cover property (@(posedge aclk) compare_match);
	c_div8: cover property (@(posedge aclk) inc && q.ctrl[5:4] == 2'b11);
	c_wide: cover property (@(posedge aclk) do_wr && q.ctrl[ctrl_wide_bit]);
endmodule

// File: tmr_pkg.sv
// Package with register map, field positions and codes for the timer block.
package tmr_pkg;
	localparam logic [7:0] ctrl_offset     = 8'h00;
	localparam logic [7:0] clksrc_offset   = 8'h04;
	localparam logic [7:0] cchigh_offset   = 8'h08;
	localparam logic [7:0] mode_offset     = 8'h0c;
	localparam logic [7:0] count_lo_offset = 8'h10;
	localparam logic [7:0] count_hi_offset = 8'h14;
	localparam logic [7:0] status_offset   = 8'h18;
	localparam int ctrl_on_bit   = 0;
	localparam int ctrl_wide_bit = 1;
	localparam int ctrl_sync_bit = 2;
	localparam int ctrl_ps_lsb   = 4;
	localparam logic [7:0] ctrl_mask   = 8'h37;
	localparam logic [7:0] clksrc_mask = 8'h0f;
	localparam logic [7:0] ctrl_reset   = 8'h00;
	localparam logic [7:0] clksrc_reset = 8'h00;
	localparam logic [7:0] cchigh_reset = 8'h00;
	localparam logic [3:0] cs_pin    = 4'h0;
	localparam logic [3:0] cs_sysq   = 4'h1;
	localparam logic [3:0] cs_sys    = 4'h2;
	localparam logic [3:0] cs_t0ovf  = 4'h9;
	localparam logic [3:0] cs_cell1  = 4'ha;
	localparam logic [3:0] cs_res_lo = 4'he;
	localparam logic [1:0] resp_okay   = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;
	typedef enum logic [1:0]
	{
		fn_off     = 2'b00,
		fn_capture = 2'b01,
		fn_compare = 2'b10,
		fn_pwm     = 2'b11
	} unit_function_mode_t;
endpackage
